//--- hw/pipc_defines.vh
/*
 * Register offsets, field positions and reset values for the pin interrupt
 * and port control block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PIPC_DEFINES_VH
`define PIPC_DEFINES_VH

// Register offsets on the plain register port.
`define PIPC_ADDR_W           4
`define PIPC_OFS_A_DATA       4'h0
`define PIPC_OFS_A_DIR        4'h1
`define PIPC_OFS_A_PULL       4'h2
`define PIPC_OFS_A_STAT       4'h3
`define PIPC_OFS_A_SEL        4'h4
`define PIPC_OFS_A_EDGE       4'h5
`define PIPC_OFS_B_PULL       4'h6
`define PIPC_OFS_B_STAT       4'h7
`define PIPC_OFS_B_SEL        4'h8
`define PIPC_OFS_B_EDGE       4'h9

// Status and control field positions.
`define PIPC_SC_MODE          0
`define PIPC_SC_IE            1
`define PIPC_SC_ACK           2
`define PIPC_SC_IF            3

// Reset values.
`define PIPC_RST_NIBBLE       4'h0
`define PIPC_RST_BYTE         8'h00

`endif

//--- hw/pipc_port_irq.v
/*
 * One four-pin interrupt port: synchroniser, edge and level detection,
 * sticky flag with acknowledge and the interrupt request.
 * Assumes a synchronous reset copy and one-cycle acknowledge pulses.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pipc_defines.vh"

module pipc_port_irq #(
   parameter PINS = 4
) (
   input  wire            clk_in,
   input  wire            rst_n_in,
   input  wire [PINS-1:0] pin_in,
   input  wire [PINS-1:0] sel_in,
   input  wire [PINS-1:0] edge_sel_in,
   input  wire            mode_in,
   input  wire            irq_enable_in,
   input  wire            ack_in,
   output wire [PINS-1:0] pin_sync_out,
   output reg             flag_out,
   output reg             irq_out
);

   reg  [PINS-1:0] meta_q;
   reg  [PINS-1:0] sync_q;
   reg  [PINS-1:0] prev_q;
   wire [PINS-1:0] norm_now;
   wire [PINS-1:0] norm_prev;
   wire [PINS-1:0] edge_hit;
   wire [PINS-1:0] level_hit;
   wire            set_flag;
   wire            clr_flag;

   // Two flops guard against metastability; sync_q and its delayed copy prev_q feed detection.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= `PIPC_RST_NIBBLE;
         sync_q <= `PIPC_RST_NIBBLE;
         prev_q <= `PIPC_RST_NIBBLE;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign pin_sync_out = sync_q;

   // Invert low-active pins so asserted always reads as one.
   assign norm_now  = sync_q ^ ~edge_sel_in;
   assign norm_prev = prev_q ^ ~edge_sel_in;

   // An edge needs a deasserted sample followed by an asserted one.
   assign edge_hit  = sel_in & norm_now & ~norm_prev;
   assign level_hit = sel_in & norm_now;
   assign set_flag  = (|edge_hit) | (mode_in & (|level_hit));
   // In level mode an asserted selected pin blocks the acknowledge.
   assign clr_flag  = ack_in & ~(mode_in & (|level_hit));

   // Set wins over clear so an event in the acknowledge cycle is kept.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_out <= 1'b0;
         irq_out  <= 1'b0;
      end else begin
         if (set_flag) begin
            flag_out <= 1'b1;
         end else if (clr_flag) begin
            flag_out <= 1'b0;
         end
         irq_out <= irq_enable_in & (flag_out | set_flag);
      end
   end

endmodule
`default_nettype wire

//--- hw/pipc_top.v
/*
 * Pin interrupt logic for two four-pin ports plus the data and direction
 * registers of the first port, behind a plain register port.
 * Assumes asynchronous pin inputs, one-cycle strobes that never overlap,
 * and an outside pad that resolves drive, pull-up and pull-down.
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pipc_defines.vh"

module pipc_top #(
   parameter PINS = 4
) (
   input  wire                    mclk_in,
   input  wire                    rst_n_in,
   input  wire [`PIPC_ADDR_W-1:0] addr_in,
   input  wire [7:0]              wdata_in,
   input  wire                    wr_in,
   input  wire                    rd_in,
   output reg  [7:0]              rdata_out,
   input  wire [PINS-1:0]         port_a_pin_in,
   output reg  [PINS-1:0]         port_a_pin_out,
   output reg  [PINS-1:0]         port_a_pin_oe_out,
   output reg  [PINS-1:0]         port_a_pull_up_out,
   output reg  [PINS-1:0]         port_a_pull_down_out,
   input  wire [PINS-1:0]         port_b_pin_in,
   output reg  [PINS-1:0]         port_b_pull_up_out,
   output reg  [PINS-1:0]         port_b_pull_down_out,
   output reg                     irq_a_out,
   output reg                     irq_b_out,
   output reg                     wake_out
);

   reg             rst_meta_q;
   reg             rst_sync_q;
   reg [PINS-1:0]  data_q;
   reg [PINS-1:0]  dir_q;
   reg [PINS-1:0]  pull_a_q;
   reg [PINS-1:0]  pull_b_q;
   reg [PINS-1:0]  sel_a_q;
   reg [PINS-1:0]  sel_b_q;
   reg [PINS-1:0]  edge_a_q;
   reg [PINS-1:0]  edge_b_q;
   reg             mode_a_q;
   reg             mode_b_q;
   reg             ie_a_q;
   reg             ie_b_q;
   reg [7:0]       rdata_d;
   wire            ack_a;
   wire            ack_b;
   wire            flag_a;
   wire            flag_b;
   wire            irq_a;
   wire            irq_b;
   wire [PINS-1:0] sync_a;
   wire [PINS-1:0] sync_b;
   wire [PINS-1:0] read_a;

   // Reset is asserted at once but released through two flops.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Acknowledge is a write pulse of one to the ack field; it is never stored.
   assign ack_a = wr_in & (addr_in == `PIPC_OFS_A_STAT) & wdata_in[`PIPC_SC_ACK];
   assign ack_b = wr_in & (addr_in == `PIPC_OFS_B_STAT) & wdata_in[`PIPC_SC_ACK];

   // Register writes; the flag field is not writable from software.
   always @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         data_q   <= `PIPC_RST_NIBBLE;
         dir_q    <= `PIPC_RST_NIBBLE;
         pull_a_q <= `PIPC_RST_NIBBLE;
         pull_b_q <= `PIPC_RST_NIBBLE;
         sel_a_q  <= `PIPC_RST_NIBBLE;
         sel_b_q  <= `PIPC_RST_NIBBLE;
         edge_a_q <= `PIPC_RST_NIBBLE;
         edge_b_q <= `PIPC_RST_NIBBLE;
         mode_a_q <= 1'b0;
         mode_b_q <= 1'b0;
         ie_a_q   <= 1'b0;
         ie_b_q   <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == `PIPC_OFS_A_DATA) begin
            data_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_A_DIR) begin
            dir_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_A_PULL) begin
            pull_a_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_A_STAT) begin
            mode_a_q <= wdata_in[`PIPC_SC_MODE];
            ie_a_q   <= wdata_in[`PIPC_SC_IE];
         end else if (addr_in == `PIPC_OFS_A_SEL) begin
            sel_a_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_A_EDGE) begin
            edge_a_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_B_PULL) begin
            pull_b_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_B_STAT) begin
            mode_b_q <= wdata_in[`PIPC_SC_MODE];
            ie_b_q   <= wdata_in[`PIPC_SC_IE];
         end else if (addr_in == `PIPC_OFS_B_SEL) begin
            sel_b_q <= wdata_in[PINS-1:0];
         end else if (addr_in == `PIPC_OFS_B_EDGE) begin
            edge_b_q <= wdata_in[PINS-1:0];
         end
      end
   end

   // One detector per interrupt port; both serve as wake sources.
   pipc_port_irq #(
      .PINS          (PINS)
   ) u_port_a (
      .clk_in        (mclk_in),
      .rst_n_in      (rst_sync_q),
      .pin_in        (port_a_pin_in),
      .sel_in        (sel_a_q),
      .edge_sel_in   (edge_a_q),
      .mode_in       (mode_a_q),
      .irq_enable_in (ie_a_q),
      .ack_in        (ack_a),
      .pin_sync_out  (sync_a),
      .flag_out      (flag_a),
      .irq_out       (irq_a)
   );

   pipc_port_irq #(
      .PINS          (PINS)
   ) u_port_b (
      .clk_in        (mclk_in),
      .rst_n_in      (rst_sync_q),
      .pin_in        (port_b_pin_in),
      .sel_in        (sel_b_q),
      .edge_sel_in   (edge_b_q),
      .mode_in       (mode_b_q),
      .irq_enable_in (ie_b_q),
      .ack_in        (ack_b),
      .pin_sync_out  (sync_b),
      .flag_out      (flag_b),
      .irq_out       (irq_b)
   );

   // Inputs read the synchronised pin, outputs read back the latch.
   assign read_a = (dir_q & data_q) | (~dir_q & sync_a);

   // Read mux; unused bits and the acknowledge field read as zero.
   always @* begin
      rdata_d = `PIPC_RST_BYTE;
      if (addr_in == `PIPC_OFS_A_DATA) begin
         rdata_d[PINS-1:0] = read_a;
      end else if (addr_in == `PIPC_OFS_A_DIR) begin
         rdata_d[PINS-1:0] = dir_q;
      end else if (addr_in == `PIPC_OFS_A_PULL) begin
         rdata_d[PINS-1:0] = pull_a_q;
      end else if (addr_in == `PIPC_OFS_A_STAT) begin
         rdata_d[`PIPC_SC_MODE] = mode_a_q;
         rdata_d[`PIPC_SC_IE]   = ie_a_q;
         rdata_d[`PIPC_SC_IF]   = flag_a;
      end else if (addr_in == `PIPC_OFS_A_SEL) begin
         rdata_d[PINS-1:0] = sel_a_q;
      end else if (addr_in == `PIPC_OFS_A_EDGE) begin
         rdata_d[PINS-1:0] = edge_a_q;
      end else if (addr_in == `PIPC_OFS_B_PULL) begin
         rdata_d[PINS-1:0] = pull_b_q;
      end else if (addr_in == `PIPC_OFS_B_STAT) begin
         rdata_d[`PIPC_SC_MODE] = mode_b_q;
         rdata_d[`PIPC_SC_IE]   = ie_b_q;
         rdata_d[`PIPC_SC_IF]   = flag_b;
      end else if (addr_in == `PIPC_OFS_B_SEL) begin
         rdata_d[PINS-1:0] = sel_b_q;
      end else if (addr_in == `PIPC_OFS_B_EDGE) begin
         rdata_d[PINS-1:0] = edge_b_q;
      end
   end

   // All outputs come from flops; pad controls lag registers by one cycle.
   // Nothing here is cleared by a stop state, so pin latches simply hold.
   always @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_out            <= `PIPC_RST_BYTE;
         port_a_pin_out       <= `PIPC_RST_NIBBLE;
         port_a_pin_oe_out    <= `PIPC_RST_NIBBLE;
         port_a_pull_up_out   <= `PIPC_RST_NIBBLE;
         port_a_pull_down_out <= `PIPC_RST_NIBBLE;
         port_b_pull_up_out   <= `PIPC_RST_NIBBLE;
         port_b_pull_down_out <= `PIPC_RST_NIBBLE;
         irq_a_out            <= 1'b0;
         irq_b_out            <= 1'b0;
         wake_out             <= 1'b0;
      end else begin
         rdata_out            <= rd_in ? rdata_d : `PIPC_RST_BYTE;
         port_a_pin_out       <= data_q;
         port_a_pin_oe_out    <= dir_q;
         // Pulls are off on driven pins; polarity follows edge select.
         port_a_pull_up_out   <= pull_a_q & ~dir_q & ~edge_a_q;
         port_a_pull_down_out <= pull_a_q & ~dir_q & edge_a_q;
         port_b_pull_up_out   <= pull_b_q & ~edge_b_q;
         port_b_pull_down_out <= pull_b_q & edge_b_q;
         irq_a_out            <= irq_a;
         irq_b_out            <= irq_b;
         // Wake is the raw flag so it works with the CPU masked.
         wake_out             <= flag_a | flag_b;
      end
   end

endmodule
`default_nettype wire

//--- test/pipc_top_assertions.sv
/* Port-level properties of the pin interrupt and port control block.
   Assumes binding into pipc_top and a bench that keeps port A quiet
   around an acknowledge. */
`timescale 1ns/100ps
`default_nettype none
module pipc_top_assertions #(
   parameter PINS = 4
) (
   input wire logic            mclk_in,
   input wire logic            rst_n_in,
   input wire logic [3:0]      addr_in,
   input wire logic [7:0]      wdata_in,
   input wire logic            wr_in,
   input wire logic            rd_in,
   input wire logic [7:0]      rdata_out,
   input wire logic [PINS-1:0] port_a_pin_in,
   input wire logic [PINS-1:0] port_a_pin_out,
   input wire logic [PINS-1:0] port_a_pin_oe_out,
   input wire logic [PINS-1:0] port_a_pull_up_out,
   input wire logic [PINS-1:0] port_a_pull_down_out,
   input wire logic            irq_a_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // Quiet pins mean no edge is still travelling through the synchroniser.
   sequence quiet_a;
      $stable(port_a_pin_in) [*6];
   endsequence
   sequence ack_edge_a;
      wr_in && addr_in == 4'h3 && wdata_in[2:0] == 3'h6;
   endsequence
   // Interrupt, register and pad relations.
   chk_ack_clears: assert property (quiet_a ##0 ack_edge_a |-> ##[1:3] !irq_a_out)
      else $error("acknowledge did not drop the request");
   chk_ie_masks: assert property (wr_in && addr_in == 4'h3 && !wdata_in[1] |-> ##[1:3] !irq_a_out)
      else $error("request stands with enable off");
   chk_ack_reads_zero: assert property ($past(rd_in) && $past(addr_in) == 4'h3 |-> !rdata_out[2])
      else $error("acknowledge bit read as one");
   chk_unused_bits: assert property ($past(rd_in) && $past(addr_in) < 4'h2 |-> rdata_out[7:4] == 4'h0)
      else $error("unused data bits not zero");
   // The pad outputs are flopped once more after the register, so they show a write two edges on.
   chk_data_latch: assert property (wr_in && addr_in == 4'h0 |=> ##1 {4'h0, port_a_pin_out} == ($past(wdata_in, 2) & 8'h0f))
      else $error("data latch missed a write");
   chk_dir_latch: assert property (wr_in && addr_in == 4'h1 |=> ##1 {4'h0, port_a_pin_oe_out} == ($past(wdata_in, 2) & 8'h0f))
      else $error("direction missed a write");
   chk_out_readback: assert property (rd_in && addr_in == 4'h0 |=> (rdata_out[3:0] & $past(port_a_pin_oe_out))
      == ($past(port_a_pin_out) & $past(port_a_pin_oe_out))) else $error("output bits misread");
   chk_pull_off_out: assert property ((port_a_pin_oe_out & (port_a_pull_up_out | port_a_pull_down_out)) == 4'h0)
      else $error("pull active on an output");
   chk_pull_one_kind: assert property ((port_a_pull_up_out & port_a_pull_down_out) == 4'h0)
      else $error("pull up and down together");
endmodule
bind pipc_top pipc_top_assertions #(.PINS(PINS)) pipc_top_assertions_inst (.mclk_in, .rst_n_in,
   .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .port_a_pin_in, .port_a_pin_out,
   .port_a_pin_oe_out, .port_a_pull_up_out, .port_a_pull_down_out, .irq_a_out);
`default_nettype wire

//--- test/pipc_pin_model.sv
/* Board around the pins: outside drivers, pad pulls and floating pads.
   Assumes the drive and pull outputs of pipc_top; the bench sets drivers. */
`timescale 1ns/100ps
`default_nettype none
module pipc_pin_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] a_en_in,
   input  wire logic [3:0] a_drv_in,
   input  wire logic [3:0] b_en_in,
   input  wire logic [3:0] b_drv_in,
   input  wire logic [3:0] a_out_in,
   input  wire logic [3:0] a_oe_in,
   input  wire logic [3:0] a_up_in,
   input  wire logic [3:0] a_dn_in,
   input  wire logic [3:0] b_up_in,
   input  wire logic [3:0] b_dn_in,
   output logic      [3:0] a_pin_out,
   output logic      [3:0] b_pin_out
);
   logic [3:0] float_q = 4'h5;
   // A pad nobody holds flips every cycle, so a stale level never passes.
   always @(posedge clk_in) begin
      float_q <= ~float_q;
   end
   // Chip drive, then outside drive, then pulls; a pull-down gives zero.
   assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & a_en_in & a_drv_in)
      | (~a_oe_in & ~a_en_in & (a_up_in | (~a_dn_in & float_q)));
   assign b_pin_out = (b_en_in & b_drv_in) | (~b_en_in & (b_up_in | (~b_dn_in & float_q)));
endmodule
`default_nettype wire

//--- test/pipc_top_test.sv
/* Self-checking bench: register rows, pin interrupt cases, mid-run reset.
   Assumes the pin model on the pads and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h expected %h", $time, g, e); end end
module pipc_top_test;
   logic        mclk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [3:0]  addr_in = 4'h0;
   logic [7:0]  wdata_in = 8'h00;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic [3:0]  a_en = 4'h0, a_drv = 4'h0, b_en = 4'h0, b_drv = 4'h0;
   wire  [7:0]  rdata_out;
   wire  [3:0]  a_pin, a_out, a_oe, a_up, a_dn, b_pin, b_up, b_dn;
   wire         irq_a_out, irq_b_out, wake_out;
   int          bad_count = 0, checks = 0, cyc = 0;
   // Rows: index, value written, value read back.
   logic [19:0] rows [0:9] = '{20'h1ff0f, 20'h0f303, 20'h30c00, 20'h5fa0a, 20'h2ff0f,
                               20'h60f0f, 20'h90c0c, 20'h70303, 20'h80000, 20'hcff00};
   pipc_top #(.PINS(4)) pipc_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .port_a_pin_in(a_pin), .port_a_pin_out(a_out),
      .port_a_pin_oe_out(a_oe), .port_a_pull_up_out(a_up), .port_a_pull_down_out(a_dn),
      .port_b_pin_in(b_pin), .port_b_pull_up_out(b_up), .port_b_pull_down_out(b_dn),
      .irq_a_out(irq_a_out), .irq_b_out(irq_b_out), .wake_out(wake_out));
   pipc_pin_model pipc_pin_model_inst (.clk_in(mclk_in), .a_en_in(a_en), .a_drv_in(a_drv),
      .b_en_in(b_en), .b_drv_in(b_drv), .a_out_in(a_out), .a_oe_in(a_oe), .a_up_in(a_up),
      .a_dn_in(a_dn), .b_up_in(b_up), .b_dn_in(b_dn), .a_pin_out(a_pin), .b_pin_out(b_pin));
   // Clock and a cycle ceiling well above the few hundred cycles needed.
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      {rd_in, addr_in} <= {1'b1, a};
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, e)
   endtask
   task automatic idle;
      repeat (8) @(posedge mclk_in);
      #1;
   endtask
   // Main sequence.
   initial begin
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      foreach (rows[i]) begin
         wr_reg(rows[i][19:16], rows[i][15:8]);
         rd_chk(rows[i][19:16], rows[i][7:0]);
      end
      #1 `CHK({a_out, a_oe, a_up | a_dn}, 12'h3f0)
      `CHK({b_up, b_dn}, 8'h3c)
      wr_reg(4'h1, 8'h00);
      idle();
      `CHK({a_up, a_dn}, 8'h5a)
      rd_chk(4'h0, 8'h05);
      $display("test registers done");
      // Falling edge on pin 0; set-up follows the advised order.
      {a_en, a_drv} <= 8'hff;
      wr_reg(4'h3, 8'h00);
      wr_reg(4'h5, 8'h00);
      wr_reg(4'h2, 8'h00);
      wr_reg(4'h4, 8'h01);
      idle();
      wr_reg(4'h3, 8'h04);
      wr_reg(4'h3, 8'h02);
      a_drv <= 4'hd;
      idle();
      `CHK(irq_a_out, 1'b0)
      a_drv <= 4'hc;
      idle();
      `CHK({irq_a_out, wake_out}, 2'b11)
      a_drv <= 4'hf;
      idle();
      wr_reg(4'h3, 8'h06);
      idle();
      `CHK(irq_a_out, 1'b0)
      $display("test falling edge done");
      // Rising select while the pin already sits high.
      wr_reg(4'h3, 8'h00);
      wr_reg(4'h5, 8'h01);
      wr_reg(4'h3, 8'h04);
      wr_reg(4'h3, 8'h02);
      idle();
      `CHK(irq_a_out, 1'b0)
      a_drv <= 4'he;
      idle();
      `CHK(irq_a_out, 1'b0)
      a_drv <= 4'hf;
      idle();
      `CHK(irq_a_out, 1'b1)
      $display("test rising edge done");
      // Port B level mode, high level on pin 2.
      wr_reg(4'h7, 8'h01);
      wr_reg(4'h8, 8'h04);
      wr_reg(4'h7, 8'h05);
      wr_reg(4'h7, 8'h03);
      {b_en, b_drv} <= 8'h44;
      idle();
      `CHK(irq_b_out, 1'b1)
      wr_reg(4'h7, 8'h07);
      idle();
      `CHK(irq_b_out, 1'b1)
      wr_reg(4'h7, 8'h01);
      idle();
      `CHK({irq_b_out, wake_out}, 2'b01)
      b_en <= 4'h0;
      wr_reg(4'h3, 8'h04);
      idle();
      wr_reg(4'h7, 8'h05);
      idle();
      `CHK(wake_out, 1'b0)
      $display("test level mode done");
      // Second reset in mid-run; the bench checks the port A pad outputs at zero, then reads the direction register back as zero and ends.
      rst_n_in <= 1'b0;
      @(posedge mclk_in);
      #1 `CHK({a_out, a_oe, a_up, a_dn}, 16'h0000)
      rst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd_chk(4'h1, 8'h00);
      $display("test reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
